// ===== rtl/ssgt_pkg.sv
// ssgt_pkg: constants, layouts and decode helpers of the supervisor and gate timing block
// assumes a 50 MHz system clock and a 16-bit register port with byte offsets
`default_nettype none
package ssgt_pkg;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int STEP_PS = 125000;
  localparam logic [7:0] CLK_PERIOD_NS = 8'h14;
  localparam logic [7:0] STEP_NS = 8'h7d;
  localparam int CYC_W = 9;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GATE_A = 8'h04;
  localparam logic [7:0] A_GATE_B = 8'h08;
  localparam logic [7:0] A_MASK = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_ADC = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  // field positions
  localparam int CTRL_ACT_BIT = 0;
  localparam int CTRL_SYNC_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CMD_RST_BIT = 0;
  localparam int GA_IG_LSB = 0;
  localparam int GA_TCC_LSB = 3;
  localparam int GA_TOB_LSB = 8;
  localparam int GB_DT_LSB = 0;
  localparam int GB_BL_LSB = 5;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [9:0] GATE_A_RST = 10'h000;
  localparam logic [7:0] GATE_B_RST = 8'h00;
  localparam logic [9:0] MASK_RST = 10'h3ff;
  localparam logic [4:0] TCC_MAX_CODE = 5'h1d;
  // overboost durations
  localparam int OB_SHORT_PS = 62500;
  localparam int OB_SHORT_8M_PS = 125000;
  localparam int OB_SHORT_24M_PS = 83300;
  localparam int OB_MID_PS = 125000;
  localparam int OB_LONG_PS = 250000;
  localparam logic [6:0] HS_HOLD_MA = 7'h01;
  // layout of the synchronised pin vector
  localparam int SI_STBY = 0;
  localparam int SI_OC = 1;
  localparam int SI_STALL = 5;
  localparam int SI_SW = 9;
  localparam int SI_ADCU = 10;
  localparam int SI_UVLO = 11;
  localparam int SI_THSD = 12;
  localparam int SI_THW = 13;
  localparam int SI_ADC = 14;
  localparam int SI_W = 15;
  localparam logic [14:0] SYNC_RST = 15'h0200; // switch idles open, pin in standby
  // per-gate drive phases
  localparam logic [2:0] PH_CLAMP = 3'h0;
  localparam logic [2:0] PH_BOOST = 3'h1;
  localparam logic [2:0] PH_SINK = 3'h2;
  localparam logic [2:0] PH_SRC = 3'h3;
  localparam logic [2:0] PH_HOLD = 3'h4;
  typedef enum logic [2:0] {
    S_OFF = 3'b000, S_DEAD = 3'b001, S_SRC = 3'b011, S_HOLD = 3'b010,
    S_BOOST = 3'b110, S_SINK = 3'b111
  } ssgt_hb_state_type;

  // least time rounds up to whole cycles, never below one
  function automatic logic [CYC_W-1:0] ps_to_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) c = 1;
    return c[CYC_W-1:0];
  endfunction : ps_to_cyc

  function automatic logic [CYC_W-1:0] steps_cyc(input logic [5:0] steps);
    return ps_to_cyc(int'(steps) * STEP_PS);
  endfunction : steps_cyc

  function automatic logic [6:0] gate_ma(input logic [2:0] code);
    case (code)
      3'h0: return 7'h04;
      3'h1: return 7'h08;
      3'h2: return 7'h10;
      3'h3: return 7'h18;
      3'h4: return 7'h20;
      3'h5: return 7'h40;
      default: return 7'h60;
    endcase
  endfunction : gate_ma
endpackage : ssgt_pkg
`default_nettype wire

// ===== rtl/ssgt_halfbridge.sv
// ssgt_halfbridge: commutation sequencer of one half-bridge (high and low gate)
// assumes durations in cycles, at least one, from the top; t_ob may be zero
`default_nettype none
module ssgt_halfbridge (
  input wire logic clk,
  input wire logic rst,
  input wire logic kill,
  input wire logic enable,
  input wire logic dir_req,
  input wire logic [ssgt_pkg::CYC_W-1:0] t_cc,
  input wire logic [ssgt_pkg::CYC_W-1:0] t_ob,
  input wire logic [ssgt_pkg::CYC_W-1:0] t_dt,
  input wire logic [ssgt_pkg::CYC_W-1:0] t_blank,
  input wire logic [6:0] gate_current_sel_ma,
  input wire logic [6:0] ob_ma,
  output logic [2:0] hs_phase,
  output logic [2:0] ls_phase,
  output logic [6:0] hs_ma,
  output logic [6:0] ls_ma,
  output logic blank
);
  import ssgt_pkg::*;
  ssgt_hb_state_type state_ff, nxt_state;
  logic side_ff, nxt_side;
  logic [CYC_W-1:0] cnt_ff, nxt_cnt, blank_ff, nxt_blank;
  logic cnt_done;
  logic [2:0] act_ph;
  logic [6:0] act_ma;

  assign cnt_done = (cnt_ff == '0);

  // sequence: deadtime, source, hold, then boost, sink and back to deadtime
  always_comb begin
    nxt_state = state_ff;
    nxt_side = side_ff;
    nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 1'b1;
    case (state_ff)
      S_OFF: if (enable) begin
        nxt_state = S_DEAD;
        nxt_cnt = t_dt - 1'b1;
      end
      S_DEAD: if (cnt_done) begin
        nxt_state = enable ? S_SRC : S_OFF;
        nxt_side = dir_req;
        nxt_cnt = t_cc - 1'b1;
      end
      S_SRC: if (cnt_done) nxt_state = S_HOLD;
      S_HOLD: if (!enable || dir_req != side_ff) begin
        nxt_state = (t_ob != '0) ? S_BOOST : S_SINK;
        nxt_cnt = (t_ob != '0) ? t_ob - 1'b1 : t_cc - 1'b1;
      end
      S_BOOST: if (cnt_done) begin
        nxt_state = S_SINK;
        nxt_cnt = t_cc - 1'b1;
      end
      S_SINK: if (cnt_done) begin
        nxt_state = S_DEAD; // miller clamp takes over in deadtime
        nxt_cnt = t_dt - 1'b1;
      end
      default: nxt_state = S_OFF;
    endcase
    if (kill) nxt_state = S_OFF;
  end

  // blanking starts when the turn-on completes the commutation
  assign nxt_blank = (state_ff == S_SRC && cnt_done) ? t_blank :
                     (blank_ff != '0) ? blank_ff - 1'b1 : blank_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_OFF;
      side_ff <= 1'b0;
      cnt_ff <= '0;
      blank_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      side_ff <= nxt_side;
      cnt_ff <= nxt_cnt;
      blank_ff <= nxt_blank;
    end
  end

  // phase and current of the driven gate; the other gate stays clamped
  assign act_ph = (state_ff == S_SRC) ? PH_SRC : (state_ff == S_HOLD) ? PH_HOLD :
                  (state_ff == S_BOOST) ? PH_BOOST : (state_ff == S_SINK) ? PH_SINK : PH_CLAMP;
  assign act_ma = (act_ph == PH_BOOST) ? ob_ma : (act_ph == PH_CLAMP) ? 7'h00 : gate_current_sel_ma;
  assign hs_phase = side_ff ? act_ph : PH_CLAMP;
  assign ls_phase = side_ff ? PH_CLAMP : act_ph;
  assign hs_ma = !side_ff ? 7'h00 : (act_ph == PH_HOLD) ? HS_HOLD_MA : act_ma;
  assign ls_ma = side_ff ? 7'h00 : act_ma;
  assign blank = (state_ff != S_HOLD) || (blank_ff != '0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  no_cross_a: assert property (!(hs_phase != PH_CLAMP && ls_phase != PH_CLAMP))
    else $error("both gates of a half-bridge driven");
  hs_hold_a: assert property ((state_ff == S_HOLD && side_ff) |-> hs_ma == HS_HOLD_MA)
    else $error("high-side hold current wrong");
  boost_first_a: assert property ((state_ff == S_HOLD && nxt_state == S_BOOST && !kill)
    |=> (state_ff == S_BOOST && hs_phase != PH_SINK && ls_phase != PH_SINK))
    else $error("turn-off did not start with overboost");
  blank_hold_a: assert property ($rose(state_ff == S_HOLD) |-> blank)
    else $error("comparators not blanked after commutation");
endmodule : ssgt_halfbridge
`default_nettype wire

// ===== rtl/ssgt_top.sv
// ssgt_top: standby, switch, gate timing, adc pacing, busy/sync and alarm logic
// assumes analog comparator pins are asynchronous and CMD_ERR, PWM_START, SYNC_IN,
// BUSY_IN and HB_DIR come from logic on CLK
//
// Summary of operation
// - standby low turns bridges, pump, bus off
// - standby restores defaults, disables protections
// - after standby bridges off, flag high
// - reset command restores defaults, no standby
// - switch level bit refreshed every 125 ns
// - switch falling edge sets sticky event flag
// - selector 0 halts on switch, 1 status
// - turn-on sources current, then holds gate
// - turn-off boosts, sinks, then miller clamp
// - seven gate current settings 4 to 96 mA
// - controlled time 125 ns to 3.75 us
// - overboost 0, 62.5, 125, 250 ns (shortest is 125 ns at 8 MHz, 83.3 ns at 24 MHz)
// - deadtime 125 ns to 4 us per commutation
// - comparators blanked after each commutation
// - blanking eight values 125 to 1000 ns
// - adc samples once per pwm period
// - busy/sync pin follows sync enable bit
// - alarm pin low on any alarm condition
// - masked condition leaves alarm pin alone
// - overcurrent flag low until ended and read
`default_nettype none
module ssgt_top #(
  parameter int N_ADC = 5,
  parameter int OSC_MHZ = 16,
  parameter logic [6:0] OB_MA = 7'h64
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic STBY_RST_N,
  input wire logic [ssgt_pkg::ADDR_W-1:0] ADDR,
  input wire logic [ssgt_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [ssgt_pkg::DATA_W-1:0] RDATA,
  input wire logic SW_IN,
  input wire logic [3:0] HB_DIR,
  input wire logic [3:0] OC_CMP,
  input wire logic [3:0] STALL_CMP,
  input wire logic TH_WARN,
  input wire logic TH_SD,
  input wire logic UVLO,
  input wire logic ADC_UVLO,
  input wire logic ADC_CMP,
  input wire logic CMD_ERR,
  input wire logic PWM_START,
  input wire logic BUSY_IN,
  input wire logic SYNC_IN,
  output logic [23:0] GATE_PHASE,
  output logic [55:0] GATE_MA,
  output logic CP_EN,
  output logic SPI_EN,
  output logic LOGIC_EN,
  output logic HALT,
  output logic [N_ADC-1:0] ADC_RAMP,
  output logic BUSY_O,
  output logic BUSY_OE_N,
  output logic FLAG_O,
  output logic FLAG_OE_N
);
  import ssgt_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  // overboost code to cycles; the shortest setting depends on the oscillator
  function automatic logic [CYC_W-1:0] ob_cyc(input logic [1:0] code);
    case (code)
      2'h0: return '0;
      2'h1: return (OSC_MHZ == 8) ? ps_to_cyc(OB_SHORT_8M_PS) :
                   (OSC_MHZ == 24) ? ps_to_cyc(OB_SHORT_24M_PS) : ps_to_cyc(OB_SHORT_PS);
      2'h2: return ps_to_cyc(OB_MID_PS);
      default: return ps_to_cyc(OB_LONG_PS);
    endcase
  endfunction : ob_cyc

  logic [SI_W-1:0] s1_ff, s2_ff;
  logic stby_ff, sw_prev_ff, sw_level_ff, sw_evt_ff, halt_ff;
  logic bridge_off_ff, pwr_ff, cmd_err_ff;
  logic ocd_n_ff, stall_a_n_ff, stall_b_n_ff;
  logic [1:0] ctrl_ff;
  logic [9:0] gate_a_ff, mask_ff;
  logic [7:0] gate_b_ff, acc_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic conv_ff;
  logic [N_ADC-1:0] ramp_ff, adc_res_ff;
  logic flag_oe_n_ff, busy_oe_n_ff, en_ff;
  logic [23:0] phase_ff;
  logic [55:0] ma_ff;

  // two flip-flops on every asynchronous pin; only the second stage is read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
    end else begin
      s1_ff <= {ADC_CMP, TH_WARN, TH_SD, UVLO, ADC_UVLO, SW_IN, STALL_CMP, OC_CMP, STBY_RST_N};
      s2_ff <= s1_ff;
    end
  end

  logic sw_s, adc_s, prot_en;
  logic [3:0] oc_s, stall_s;
  assign sw_s = s2_ff[SI_SW];
  assign adc_s = s2_ff[SI_ADC];
  assign oc_s = s2_ff[SI_OC +: 4];
  assign stall_s = s2_ff[SI_STALL +: 4];
  assign prot_en = !stby_ff;

  // bus strobes are ignored in standby, the serial side being off
  logic wr_ok, status_rd, wr_ctrl, wr_ga, wr_gb, wr_mask, reg_rst, reg_clr;
  assign wr_ok = WR && !stby_ff;
  assign status_rd = RD && !stby_ff && hit(ADDR, A_STATUS);
  assign wr_ctrl = wr_ok && hit(ADDR, A_CTRL);
  assign wr_ga = wr_ok && hit(ADDR, A_GATE_A);
  assign wr_gb = wr_ok && hit(ADDR, A_GATE_B);
  assign wr_mask = wr_ok && hit(ADDR, A_MASK);
  assign reg_rst = wr_ok && hit(ADDR, A_CMD) && WDATA[CMD_RST_BIT];
  assign reg_clr = stby_ff || reg_rst;

  // configuration registers; standby and the reset command share one clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= CTRL_RST;
      gate_a_ff <= GATE_A_RST;
      gate_b_ff <= GATE_B_RST;
      mask_ff <= MASK_RST;
    end else if (reg_clr) begin
      ctrl_ff <= CTRL_RST;
      gate_a_ff <= GATE_A_RST;
      gate_b_ff <= GATE_B_RST;
      mask_ff <= MASK_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= WDATA[1:0];
      if (wr_ga) gate_a_ff <= WDATA[9:0];
      if (wr_gb) gate_b_ff <= WDATA[7:0];
      if (wr_mask) mask_ff <= WDATA[9:0];
    end
  end

  // standby follows the synchronised pin; bridges come back off
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stby_ff <= 1'b1;
      bridge_off_ff <= 1'b1;
      en_ff <= 1'b0;
    end else begin
      stby_ff <= !s2_ff[SI_STBY];
      en_ff <= s2_ff[SI_STBY];
      if (reg_clr) bridge_off_ff <= 1'b1;
      else if (wr_ctrl) bridge_off_ff <= !WDATA[CTRL_RUN_BIT];
    end
  end

  // 125 ns refresh tick: fractional accumulator, exact on average at 20 ns
  logic tick;
  logic [7:0] acc_sum;
  assign acc_sum = acc_ff + CLK_PERIOD_NS;
  assign tick = (acc_sum >= STEP_NS);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_ff <= 8'h00;
      sw_level_ff <= 1'b0;
    end else begin
      acc_ff <= tick ? acc_sum - STEP_NS : acc_sum;
      if (tick) sw_level_ff <= !sw_s;
    end
  end

  // switch event flag: a new edge beats a clearing status read
  logic sw_fall;
  assign sw_fall = sw_prev_ff && !sw_s && prot_en;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sw_prev_ff <= 1'b1;
      sw_evt_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      sw_prev_ff <= sw_s;
      if (stby_ff) sw_evt_ff <= 1'b0;
      else if (sw_fall) sw_evt_ff <= 1'b1;
      else if (status_rd) sw_evt_ff <= 1'b0;
      halt_ff <= sw_fall && !ctrl_ff[CTRL_ACT_BIT];
    end
  end

  // comparators are only heard outside blanking
  logic [3:0] blank;
  logic oc_any, stall_a, stall_b;
  assign oc_any = |(oc_s & ~blank) && prot_en;
  assign stall_a = |(stall_s[1:0] & ~blank[1:0]) && prot_en;
  assign stall_b = |(stall_s[3:2] & ~blank[3:2]) && prot_en;

  // overcurrent and stall flags are active low, command error high; each waits for the event to end and a status read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ocd_n_ff <= 1'b1;
      stall_a_n_ff <= 1'b1;
      stall_b_n_ff <= 1'b1;
      cmd_err_ff <= 1'b0;
      pwr_ff <= 1'b1;
    end else if (stby_ff) begin
      ocd_n_ff <= 1'b1;
      stall_a_n_ff <= 1'b1;
      stall_b_n_ff <= 1'b1;
      cmd_err_ff <= 1'b0;
      pwr_ff <= 1'b1;
    end else begin
      if (oc_any) ocd_n_ff <= 1'b0;
      else if (status_rd) ocd_n_ff <= 1'b1;
      if (stall_a) stall_a_n_ff <= 1'b0;
      else if (status_rd) stall_a_n_ff <= 1'b1;
      if (stall_b) stall_b_n_ff <= 1'b0;
      else if (status_rd) stall_b_n_ff <= 1'b1;
      if (CMD_ERR) cmd_err_ff <= 1'b1;
      else if (status_rd) cmd_err_ff <= 1'b0;
      if (status_rd) pwr_ff <= 1'b0;
    end
  end

  // gate timing decode; out-of-range controlled-time codes saturate
  logic [4:0] tcc_code;
  logic [CYC_W-1:0] t_cc, t_ob, t_dt, t_blank;
  logic [6:0] gate_current_sel_ma;
  assign tcc_code = (gate_a_ff[GA_TCC_LSB +: 5] > TCC_MAX_CODE) ? TCC_MAX_CODE :
                    gate_a_ff[GA_TCC_LSB +: 5];
  assign t_cc = steps_cyc({1'b0, tcc_code} + 6'h01);
  assign t_ob = ob_cyc(gate_a_ff[GA_TOB_LSB +: 2]);
  assign t_dt = steps_cyc({1'b0, gate_b_ff[GB_DT_LSB +: 5]} + 6'h01);
  assign t_blank = steps_cyc({3'h0, gate_b_ff[GB_BL_LSB +: 3]} + 6'h01);
  assign gate_current_sel_ma = gate_ma(gate_a_ff[GA_IG_LSB +: 3]);

  // four half-bridges; standby kills the sequence at once
  logic drive_en;
  logic [23:0] phase_w;
  logic [55:0] ma_w;
  assign drive_en = !stby_ff && !bridge_off_ff;

  for (genvar i = 0; i < 4; i++) begin : g_hb
    ssgt_halfbridge u_hb (
      .clk(CLK),
      .rst(RST),
      .kill(stby_ff),
      .enable(drive_en),
      .dir_req(HB_DIR[i]),
      .t_cc(t_cc),
      .t_ob(t_ob),
      .t_dt(t_dt),
      .t_blank(t_blank),
      .gate_current_sel_ma(gate_current_sel_ma),
      .ob_ma(OB_MA),
      .hs_phase(phase_w[6*i+3 +: 3]),
      .ls_phase(phase_w[6*i +: 3]),
      .hs_ma(ma_w[14*i+7 +: 7]),
      .ls_ma(ma_w[14*i +: 7]),
      .blank(blank[i])
    );
  end

  // registered drive outputs, forced off in standby
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_ff <= '0;
      ma_ff <= '0;
    end else begin
      phase_ff <= stby_ff ? '0 : phase_w;
      ma_ff <= stby_ff ? '0 : ma_w;
    end
  end

  // ramp-compare conversion started once per pwm period
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      conv_ff <= 1'b0;
      ramp_ff <= '0;
      adc_res_ff <= '0;
    end else if (stby_ff) begin
      conv_ff <= 1'b0;
      ramp_ff <= '0;
      adc_res_ff <= '0;
    end else if (PWM_START) begin
      conv_ff <= 1'b1;
      ramp_ff <= '0;
    end else if (conv_ff) begin
      if (adc_s || ramp_ff == '1) begin
        conv_ff <= 1'b0;
        adc_res_ff <= ramp_ff;
      end else begin
        ramp_ff <= ramp_ff + 1'b1;
      end
    end
  end

  // alarm and busy pins: open drain, enable low pulls the wire low
  logic [9:0] alarm_cond;
  logic alarm_any;
  assign alarm_cond = {cmd_err_ff, sw_evt_ff, s2_ff[SI_ADCU], s2_ff[SI_UVLO], s2_ff[SI_THSD],
                       s2_ff[SI_THW], !ocd_n_ff, !stall_b_n_ff, !stall_a_n_ff, pwr_ff};
  assign alarm_any = prot_en && |(alarm_cond & mask_ff);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flag_oe_n_ff <= 1'b1;
      busy_oe_n_ff <= 1'b1;
    end else begin
      flag_oe_n_ff <= !alarm_any;
      busy_oe_n_ff <= !(prot_en && (ctrl_ff[CTRL_SYNC_BIT] ? SYNC_IN : BUSY_IN));
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  logic [DATA_W-1:0] status_w, rd_mux;
  assign status_w = {4'h0, pwr_ff, cmd_err_ff, !s2_ff[SI_ADCU], !s2_ff[SI_UVLO],
                     s2_ff[SI_THSD], s2_ff[SI_THW], stall_b_n_ff, stall_a_n_ff,
                     ocd_n_ff, sw_evt_ff, sw_level_ff, bridge_off_ff};
  assign rd_mux = hit(ADDR, A_CTRL) ? {13'h0000, !bridge_off_ff, ctrl_ff} :
                  hit(ADDR, A_GATE_A) ? {6'h00, gate_a_ff} :
                  hit(ADDR, A_GATE_B) ? {8'h00, gate_b_ff} :
                  hit(ADDR, A_MASK) ? {6'h00, mask_ff} :
                  hit(ADDR, A_STATUS) ? status_w :
                  hit(ADDR, A_ADC) ? DATA_W'(adc_res_ff) : '0;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) rdata_ff <= '0;
    else rdata_ff <= (RD && !stby_ff) ? rd_mux : '0;
  end

  assign RDATA = rdata_ff;
  assign GATE_PHASE = phase_ff;
  assign GATE_MA = ma_ff;
  assign CP_EN = en_ff;
  assign SPI_EN = en_ff;
  assign LOGIC_EN = en_ff;
  assign HALT = halt_ff;
  assign ADC_RAMP = ramp_ff;
  assign BUSY_O = 1'b0;
  assign BUSY_OE_N = busy_oe_n_ff;
  assign FLAG_O = 1'b0;
  assign FLAG_OE_N = flag_oe_n_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  stby_gates_a: assert property (stby_ff |=> (GATE_PHASE == '0 && GATE_MA == '0))
    else $error("gates driven in standby");
  stby_pump_a: assert property (stby_ff |-> (!CP_EN && !SPI_EN && !LOGIC_EN))
    else $error("pump or logic enabled in standby");
  stby_defaults_a: assert property (stby_ff |=> (ctrl_ff == CTRL_RST && gate_a_ff == GATE_A_RST
    && gate_b_ff == GATE_B_RST && mask_ff == MASK_RST && FLAG_OE_N))
    else $error("registers not at defaults in standby");
  exit_off_a: assert property ($fell(stby_ff) |-> (bridge_off_ff && phase_w == '0))
    else $error("bridges not off on standby exit");
  cmd_reset_a: assert property (reg_rst |=> (gate_a_ff == GATE_A_RST && gate_b_ff == GATE_B_RST
    && mask_ff == MASK_RST && !stby_ff))
    else $error("reset command did not restore defaults");
  sw_level_a: assert property ((tick && !stby_ff) |=> (sw_level_ff == !$past(sw_s)))
    else $error("switch level bit not refreshed");
  sw_event_a: assert property (sw_fall |=> sw_evt_ff)
    else $error("switch edge lost");
  halt_sel_a: assert property ((sw_fall && !ctrl_ff[CTRL_ACT_BIT]) |=> HALT ##1 !HALT)
    else $error("halt pulse wrong");
  halt_mute_a: assert property ((ctrl_ff[CTRL_ACT_BIT] && !wr_ctrl) |=> !HALT)
    else $error("halt with status-only switch");
  adc_take_a: assert property ((conv_ff && !PWM_START && !stby_ff && (adc_s || ramp_ff == '1))
    |=> (adc_res_ff == $past(ramp_ff) && !conv_ff))
    else $error("conversion not stored");
  sync_pin_a: assert property ((prot_en && ctrl_ff[CTRL_SYNC_BIT] && SYNC_IN) |=> !BUSY_OE_N)
    else $error("sync not on busy pin");
  alarm_on_a: assert property (alarm_any |=> !FLAG_OE_N)
    else $error("alarm pin not pulled");
  alarm_mask_a: assert property (!(|(alarm_cond & mask_ff)) |=> FLAG_OE_N)
    else $error("masked alarm drives pin");
  ocd_hold_a: assert property ((!ocd_n_ff && !stby_ff && (oc_any || !status_rd))
    |=> !ocd_n_ff)
    else $error("overcurrent flag released early");
endmodule : ssgt_top
`default_nettype wire

// ===== dv/ssgt_far_model.sv
// ssgt_far_model: switch contact and bridge comparators beyond the block
// assumes the bench commands contact closure and fault levels
`default_nettype none
module ssgt_far_model (
  input wire logic closed,
  input wire logic oc_fault,
  output logic sw_pin,
  output logic [3:0] oc_cmp
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up holds the pin high while the contact is open
  assign sw_pin = !closed;
  assign oc_cmp = {4{oc_fault}};
endmodule : ssgt_far_model
`default_nettype wire

// ===== dv/testbench.sv
// testbench: register-port sequences with expected values for ssgt_top
// assumes the far model for switch and comparators, one 50 MHz clock
`default_nettype none
module testbench import ssgt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0, RST = 1'b1, STBY_RST_N = 1'b1, WR = 1'b0, RD = 1'b0;
  logic BUSY_IN = 1'b0, SYNC_IN = 1'b0, closed = 1'b0, oc = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000, q;
  logic [11:0] z = 12'h000;
  logic [3:0] HB_DIR = 4'h0;
  wire [15:0] RDATA;
  wire [23:0] GATE_PHASE;
  wire [55:0] GATE_MA;
  wire [4:0] ADC_RAMP;
  wire [3:0] OC_CMP;
  wire SW_IN, CP_EN, SPI_EN, LOGIC_EN, HALT, BUSY_O, BUSY_OE_N, FLAG_O, FLAG_OE_N;
  int failures = 0, checked = 0, halts = 0;
  always #10 CLK = ~CLK;
  // halt pulses last one cycle, so count them rather than poll
  always @(posedge CLK) if (HALT === 1'b1) halts <= halts + 1;
  ssgt_far_model far (.closed(closed), .oc_fault(oc), .sw_pin(SW_IN), .oc_cmp(OC_CMP));
  ssgt_top dut (.CLK(CLK), .RST(RST), .STBY_RST_N(STBY_RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SW_IN(SW_IN), .HB_DIR(HB_DIR), .OC_CMP(OC_CMP),
    .STALL_CMP(z[3:0]), .TH_WARN(z[4]), .TH_SD(z[5]), .UVLO(z[6]), .ADC_UVLO(z[7]),
    .ADC_CMP(z[8]), .CMD_ERR(z[9]), .PWM_START(z[10]), .BUSY_IN(BUSY_IN),
    .SYNC_IN(SYNC_IN), .GATE_PHASE(GATE_PHASE), .GATE_MA(GATE_MA), .CP_EN(CP_EN),
    .SPI_EN(SPI_EN), .LOGIC_EN(LOGIC_EN), .HALT(HALT), .ADC_RAMP(ADC_RAMP),
    .BUSY_O(BUSY_O), .BUSY_OE_N(BUSY_OE_N), .FLAG_O(FLAG_O), .FLAG_OE_N(FLAG_OE_N));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 q = RDATA;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc
  task automatic complete_run;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // the whole sequence takes well under 1000 cycles
  initial begin
    #50000;
    failures++;
    complete_run();
  end
  initial begin
    cyc(10);
    RST <= 1'b0;
    cyc(20);
    chk(FLAG_OE_N, 1'b0);
    rd(A_STATUS); chk(q, 16'h0b39);
    cyc(3); chk(FLAG_OE_N, 1'b1);
    rd(A_MASK); chk(q, 16'h03ff);
    // close the contact with halting selected
    @(posedge CLK) closed <= 1'b1;
    cyc(12); chk(halts, 1);
    chk(FLAG_OE_N, 1'b0);
    rd(A_STATUS); chk(q, 16'h033f);
    rd(A_STATUS); chk(q, 16'h033b);
    // status-only mode: events recorded, no halt, masked from the pin
    wr(A_CTRL, 16'h0001);
    @(posedge CLK) closed <= 1'b0;
    cyc(12);
    @(posedge CLK) closed <= 1'b1;
    cyc(12); chk(halts, 1);
    wr(A_MASK, 16'h02ff);
    cyc(3); chk(FLAG_OE_N, 1'b1);
    rd(A_STATUS); chk(q, 16'h033f);
    // run the bridges: low gates end holding at the selected current
    wr(A_GATE_A, 16'h0006);
    wr(A_CTRL, 16'h0004);
    cyc(60); chk(GATE_PHASE[5:0], {PH_CLAMP, PH_HOLD});
    chk(GATE_MA[6:0], 7'h60);
    wr(A_CMD, 16'h0001);
    rd(A_MASK); chk(q, 16'h03ff);
    chk(CP_EN, 1'b1);
    BUSY_IN <= 1'b1;
    cyc(3); chk(BUSY_OE_N, 1'b0);
    wr(A_CTRL, 16'h0002);
    cyc(3); chk(BUSY_OE_N, 1'b1);
    wr(A_MASK, 16'h0000);
    @(posedge CLK) STBY_RST_N <= 1'b0;
    cyc(10); chk({CP_EN, SPI_EN, LOGIC_EN, GATE_PHASE}, 27'h0);
    @(posedge CLK) STBY_RST_N <= 1'b1;
    cyc(10);
    rd(A_MASK); chk(q, 16'h03ff);
    // pwm start with the comparator silent: ramp runs to all ones and is kept
    @(posedge CLK) z[10] <= 1'b1;
    @(posedge CLK) z[10] <= 1'b0;
    cyc(40); chk(ADC_RAMP, 5'h1f);
    rd(A_ADC); chk(q, 16'h001f);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
